// ===== design/pcf_fuse_prog.sv
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
// What this block does
// - threshold set only by supply pulse codes
// - provisional bits clear and set repeatedly
// - blown lock fuse ignores all further sequences
// - release follows operate by fixed hysteresis
// - operate range split into 64 steps
// - six data bits, one bitfield each
// - hold level keeps every bitfield
// - each mid pulse after keying increments address counter, up to 127
// - short high delimits, long high blows fuse
// - supply near zero clears bitfields, counters and decoder state; fuses stay
// - same sequence; fuse pulse makes it permanent
// - keying: high, seven mids, high enables
// - lock bit at address 65 with fuse
// - unset bitfields read as zero
module pcf_fuse_prog
    import pcf_pkg::*;
(
    // clock and reset
    input  wire logic          ref_clk_i,
    input  wire logic          rst_i,
    // supply level comparators
    input  wire logic [1:0]    supply_level_i,
    // register port
    input  wire pcf_bus_req_t  bus_req_i,
    output logic [31:0]        bus_rdata_o,
    // threshold codes
    output logic [5:0]         operate_threshold_o,
    output logic [5:0]         release_threshold_o,
    // fuse control
    output logic               locked_o,
    output logic               fuse_blow_o,
    output logic [FIELDS-1:0]  fuse_sel_o
);
    logic [1:0]        level_s;
    pcf_evt_t          evt;
    pcf_state_t        state_r;
    logic [3:0]        key_cnt_r;
    logic [ADDR_W-1:0] addr_r;
    logic [1:0]        ctrl_r;
    logic [FIELDS-1:0] field_w;
    logic [FIELDS-1:0] fuse_w;
    logic [FIELDS-1:0] field_sel;
    logic              active;
    logic              key_ok;
    logic              set_go;
    logic              blow_go;
    logic [5:0]        op_nxt;
    logic [31:0]       rdata_nxt;

    pcf_sync2 #(
        .W(2)
    ) u_sync (
        .ref_clk_i(ref_clk_i),
        .rst_i    (rst_i),
        .async_i  (supply_level_i),
        .sync_o   (level_s)
    );

    pcf_pulse_class u_class (
        .ref_clk_i(ref_clk_i),
        .rst_i    (rst_i),
        .level_i  (level_s),
        .evt_o    (evt)
    );

    assign active  = ctrl_r[CTRL_PROG_BIT] && !fuse_w[LOCK_FIELD];
    // seven or more mids before closing high
    assign key_ok  = (key_cnt_r >= KEY_MIN_PULSES);
    // delimiter sets, long high also blows
    assign set_go  = active && (state_r == PCF_ST_ADDR)
                     && (evt.short_high || evt.long_high);
    // fuse pulse and the blow enable bit are the only difference
    assign blow_go = set_go && evt.long_high && ctrl_r[CTRL_BLOW_BIT];

    // decoder state driven by pulse codes, forced idle while not active
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state_r <= PCF_ST_IDLE;
        end else if (evt.zero || !active) begin
            state_r <= PCF_ST_IDLE;
        end else begin
            unique case (state_r)
                PCF_ST_IDLE: begin
                    if (evt.short_high) begin
                        state_r <= PCF_ST_KEY;
                    end
                end
                PCF_ST_KEY: begin
                    if (evt.short_high) begin
                        state_r <= key_ok ? PCF_ST_ADDR : PCF_ST_IDLE;
                    end else if (evt.long_high) begin
                        state_r <= PCF_ST_IDLE;
                    end
                end
                PCF_ST_ADDR: begin
                    if (evt.short_high || evt.long_high) begin
                        state_r <= PCF_ST_IDLE;
                    end
                end
                default: begin
                    state_r <= PCF_ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i || evt.zero) begin
            key_cnt_r <= '0;
        end else if (state_r == PCF_ST_IDLE && evt.short_high) begin
            key_cnt_r <= '0;
        end else if (state_r == PCF_ST_KEY && evt.mid_pulse
                     && key_cnt_r != KEY_CNT_MAX) begin
            key_cnt_r <= key_cnt_r + 4'h1;
        end
    end

    // address counter steps per mid pulse
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || evt.zero) begin
            addr_r <= '0;
        end else if (active && state_r == PCF_ST_KEY && evt.short_high) begin
            addr_r <= '0;
        end else if (active && state_r == PCF_ST_ADDR && evt.mid_pulse
                     && addr_r != ADDR_MAX) begin
            addr_r <= addr_r + 7'h01;
        end
    end

    // one bitfield and one fuse per entry
    for (genvar g = 0; g < FIELDS; g++) begin : g_field
        // last entry is the lock bit
        localparam logic [ADDR_W-1:0] FADDR = (g < CAL_BITS) ?
            ADDR_W'(g + 1) : LOCK_ADDR;
        logic field_r;
        logic fuse_r;

        assign field_sel[g] = (addr_r == FADDR);
        assign field_w[g]   = field_r;
        assign fuse_w[g]    = fuse_r;

        always_ff @(posedge ref_clk_i) begin
            if (rst_i || evt.zero) begin
                field_r <= 1'b0;
            end else if (set_go && field_sel[g]) begin
                field_r <= 1'b1;
            end
        end

        // long high blows the selected fuse
        always_ff @(posedge ref_clk_i) begin
            if (rst_i) begin
                fuse_r <= 1'b0;
            end else if (blow_go && field_sel[g]) begin
                fuse_r <= 1'b1;
            end
        end
    end

    // blown fuse reads one; unset reads zero
    assign op_nxt = field_w[CAL_BITS-1:0] | fuse_w[CAL_BITS-1:0];

    // release is operate minus fixed offset, or zero when operate is below the offset
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            operate_threshold_o <= '0;
            release_threshold_o <= '0;
            locked_o            <= 1'b0;
        end else begin
            operate_threshold_o <= op_nxt;
            release_threshold_o <= (op_nxt >= HYST_STEPS) ?
                                   op_nxt - HYST_STEPS : 6'h00;
            locked_o            <= fuse_w[LOCK_FIELD];
        end
    end

    // fuse drive pulse
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            fuse_blow_o <= 1'b0;
            fuse_sel_o  <= '0;
        end else begin
            fuse_blow_o <= blow_go;
            fuse_sel_o  <= blow_go ? field_sel : '0;
        end
    end

    // control register
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ctrl_r <= CTRL_RESET;
        end else if (bus_req_i.wr && bus_req_i.addr == REG_CTRL) begin
            ctrl_r <= bus_req_i.wdata[1:0];
        end
    end

    // read mux
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        unique case (bus_req_i.addr)
            REG_CTRL: begin
                rdata_nxt[1:0] = ctrl_r;
            end
            REG_STATUS: begin
                rdata_nxt[1:0] = state_r;
                rdata_nxt[2]   = fuse_w[LOCK_FIELD];
                rdata_nxt[3]   = field_w[LOCK_FIELD];
                rdata_nxt[4]   = active;
            end
            REG_CAL: begin
                rdata_nxt[5:0]   = op_nxt;
                rdata_nxt[13:8]  = fuse_w[CAL_BITS-1:0];
                rdata_nxt[21:16] = field_w[CAL_BITS-1:0];
            end
            REG_ADDR: begin
                rdata_nxt[6:0]  = addr_r;
                rdata_nxt[11:8] = key_cnt_r;
            end
            default: begin
                rdata_nxt = 32'h0000_0000;
            end
        endcase
    end

    // read data valid only the cycle after the strobe
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            bus_rdata_o <= '0;
        end else begin
            bus_rdata_o <= bus_req_i.rd ? rdata_nxt : 32'h0000_0000;
        end
    end

    a_zero_clears: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        evt.zero |=> (field_w == '0) && (state_r == PCF_ST_IDLE))
        else $error("zero level did not clear");

    a_lock_freezes: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (fuse_w[LOCK_FIELD] && !evt.zero) |=> $stable(field_w))
        else $error("bitfield changed while locked");

    a_fuse_forces: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        ##1 ((operate_threshold_o & $past(fuse_w[5:0]))
             == $past(fuse_w[5:0])))
        else $error("blown fuse bit reads zero");

    a_key_restart: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (active && state_r == PCF_ST_KEY && evt.short_high && key_ok
         && !evt.zero)
        |=> (state_r == PCF_ST_ADDR) && (addr_r == 7'h00))
        else $error("keying did not restart address");

    a_key_short: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (state_r == PCF_ST_KEY && evt.short_high && !key_ok)
        |=> state_r == PCF_ST_IDLE)
        else $error("short key entered addressing");

    a_mid_step: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (active && state_r == PCF_ST_ADDR && evt.mid_pulse && !evt.zero
         && addr_r != ADDR_MAX)
        |=> addr_r == $past(addr_r) + 7'h01)
        else $error("address did not step");

    a_release_off: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (operate_threshold_o >= HYST_STEPS)
        |-> release_threshold_o == operate_threshold_o - HYST_STEPS)
        else $error("release offset wrong");

    // blow only on long pulse and one cycle
    a_blow_cause: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $rose(fuse_blow_o) |-> $past(evt.long_high)
        ##1 !fuse_blow_o)
        else $error("fuse blow without long pulse");

    a_short_sets: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (set_go && !evt.zero && field_sel[0]) |=> field_w[0])
        else $error("delimiter did not set bit");

    // blow only while blow enable set
    a_blow_gated: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        $rose(fuse_blow_o) |-> $past(ctrl_r[CTRL_BLOW_BIT]))
        else $error("fuse blown while blow disabled");

    a_sel_onehot: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        fuse_blow_o |-> $onehot(fuse_sel_o))
        else $error("fuse select not one-hot");

    // no select outside a blow pulse
    a_sel_idle: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        !fuse_blow_o |-> (fuse_sel_o == '0))
        else $error("fuse select without blow");

    a_locked_out: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        ##1 (locked_o == $past(fuse_w[LOCK_FIELD])))
        else $error("lock output wrong");

    a_fuse_sticky: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        ##1 ((fuse_w & $past(fuse_w)) == $past(fuse_w)))
        else $error("blown fuse cleared");

    a_lock_idle: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        fuse_w[LOCK_FIELD] |=> (state_r == PCF_ST_IDLE))
        else $error("decoder left idle while locked");

    a_release_low: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        (operate_threshold_o < HYST_STEPS) |-> (release_threshold_o == 6'h00))
        else $error("release not clamped");

    // zero clears address and key count
    a_zero_addr: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        evt.zero |=> (addr_r == '0) && (key_cnt_r == '0))
        else $error("zero level left counters set");
endmodule // pcf_fuse_prog

// ===== design/pcf_pkg.sv
package pcf_pkg;

    // supply level as reported by the pin comparators
    typedef enum logic [1:0] {
        PCF_LVL_ZERO  = 2'h0,
        PCF_LVL_HOLD  = 2'h1,
        PCF_LVL_COUNT = 2'h2,
        PCF_LVL_DELIM = 2'h3
    } pcf_level_t;

    // decoder states, gray along idle -> key -> addr
    typedef enum logic [1:0] {
        PCF_ST_IDLE = 2'h0,
        PCF_ST_KEY  = 2'h1,
        PCF_ST_ADDR = 2'h3
    } pcf_state_t;

    // pulse events, each a one-cycle pulse except zero
    typedef struct packed {
        logic zero;
        logic mid_pulse;
        logic short_high;
        logic long_high;
    } pcf_evt_t;

    // register port request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [3:0]  addr;
        logic [31:0] wdata;
    } pcf_bus_req_t;

    // calibration layout
    localparam int          CAL_BITS       = 6;
    localparam int          CAL_STEPS      = 64;
    localparam int          FIELDS         = CAL_BITS + 1;
    localparam int          LOCK_FIELD     = CAL_BITS;
    localparam int          ADDR_W         = 7;
    localparam logic [6:0]  LOCK_ADDR      = 7'h41;
    localparam logic [6:0]  ADDR_MAX       = 7'h7F;
    localparam logic [3:0]  KEY_MIN_PULSES = 4'h7;
    localparam logic [3:0]  KEY_CNT_MAX    = 4'hF;
    localparam logic [5:0]  HYST_STEPS     = 6'h02;

    // pulse timing
    localparam int          CLK_KHZ        = 20000;
    localparam int          PULSE_MIN_US   = 20;
    localparam int          BLOW_MIN_US    = 100;
    localparam int          WIDTH_W        = 12;
    localparam logic [11:0] PULSE_MIN_CYC  =
        12'((PULSE_MIN_US * CLK_KHZ + 999) / 1000);
    localparam logic [11:0] BLOW_MIN_CYC   =
        12'((BLOW_MIN_US * CLK_KHZ + 999) / 1000);

    // register map
    localparam logic [3:0]  REG_CTRL       = 4'h0;
    localparam logic [3:0]  REG_STATUS     = 4'h4;
    localparam logic [3:0]  REG_CAL        = 4'h8;
    localparam logic [3:0]  REG_ADDR       = 4'hC;
    localparam int          CTRL_PROG_BIT  = 0;
    localparam int          CTRL_BLOW_BIT  = 1;
    localparam logic [1:0]  CTRL_RESET     = 2'h3;

endpackage

// ===== design/pcf_pulse_class.sv
`timescale 1ns/1ps
module pcf_pulse_class
    import pcf_pkg::*;
(
    // clock and reset
    input  wire logic ref_clk_i,
    input  wire logic rst_i,
    // synchronised level
    input  wire logic [1:0] level_i,
    // classified events
    output pcf_evt_t        evt_o
);
    logic [1:0]         prev_r;
    logic [WIDTH_W-1:0] width_r;
    logic               ended;
    logic               wide;

    assign ended = (level_i != prev_r);
    assign wide  = (width_r >= PULSE_MIN_CYC);

    // width of the level held so far, saturating
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            prev_r  <= PCF_LVL_HOLD;
            width_r <= '0;
        end else begin
            prev_r <= level_i;
            if (ended) begin
                width_r <= 12'h001;
            end else if (width_r != BLOW_MIN_CYC) begin
                width_r <= width_r + 12'h001;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            evt_o <= '0;
        end else begin
            evt_o.zero       <= (level_i == PCF_LVL_ZERO);
            evt_o.mid_pulse  <= ended && wide && (prev_r == PCF_LVL_COUNT);
            evt_o.short_high <= ended && wide && (prev_r == PCF_LVL_DELIM)
                                && (width_r < BLOW_MIN_CYC);
            evt_o.long_high  <= !ended && (prev_r == PCF_LVL_DELIM)
                                && (width_r == BLOW_MIN_CYC - 12'h001);
        end
    end
endmodule // pcf_pulse_class

// ===== design/pcf_sync2.sv
`timescale 1ns/1ps
module pcf_sync2 #(
    parameter int W = 2
) (
    // clock and reset
    input  wire logic         ref_clk_i,
    input  wire logic         rst_i,
    // asynchronous in, synchronous out
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_r;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            meta_r <= '0;
            sync_o <= '0;
        end else begin
            meta_r <= async_i;
            sync_o <= meta_r;
        end
    end
endmodule // pcf_sync2

// ===== testbench/pcf_prog_model.sv
`timescale 1ns/1ps
module pcf_prog_model
    import pcf_pkg::*;
#(
    parameter int SEG  = 402,
    parameter int LONG = 2100
) (
    // clock
    input  wire logic       ref_clk_i,
    // command from bench
    input  wire logic       start_i,
    input  wire logic [3:0] key_n_i,
    input  wire logic [6:0] addr_n_i,
    input  wire logic [1:0] op_i,
    // supply pin and state
    output logic [1:0]      supply_level_o,
    output logic            busy_o
);
    initial begin
        supply_level_o = PCF_LVL_HOLD;
        busy_o = 1'b0;
    end
    task automatic lvl(input pcf_level_t l, input int n);
        supply_level_o <= l;
        repeat (n) @(posedge ref_clk_i);
    endtask
    task automatic pulse(input pcf_level_t l, input int n);
        lvl(l, n);
        lvl(PCF_LVL_HOLD, SEG);
    endtask
    always @(posedge ref_clk_i) begin
        if (start_i) begin
            busy_o <= 1'b1;
            if (op_i == 2'h3) begin
                pulse(PCF_LVL_ZERO, SEG);
            end else begin
                pulse(PCF_LVL_DELIM, SEG);
                repeat (key_n_i) pulse(PCF_LVL_COUNT, SEG);
                pulse(PCF_LVL_DELIM, SEG);
                if (op_i != 2'h0) begin
                    repeat (addr_n_i) pulse(PCF_LVL_COUNT, SEG);
                    pulse(PCF_LVL_DELIM, (op_i == 2'h2) ? LONG : SEG);
                end
            end
            busy_o <= 1'b0;
        end
    end
endmodule // pcf_prog_model

// ===== testbench/pulse_coded_fuse_programmer_tb_top.sv
`timescale 1ns/1ps
module pulse_coded_fuse_programmer_tb_top
    import pcf_pkg::*;
;
    logic              ref_clk_i;
    logic              rst_i;
    pcf_bus_req_t      req;
    logic [31:0]       rdata;
    logic [5:0]        op_th;
    logic [5:0]        rel_th;
    logic              locked;
    logic              blow;
    logic [FIELDS-1:0] sel;
    logic [FIELDS-1:0] last_sel = '0;
    logic [1:0]        lvl;
    logic              start;
    logic [3:0]        key_n;
    logic [6:0]        addr_n;
    logic [1:0]        op;
    logic              busy;
    logic [31:0]       d;
    int                n_fail = 0;
    int                checked = 0;
    int                cyc = 0;
    int                nblow = 0;

    pcf_fuse_prog DUT (
        .ref_clk_i           (ref_clk_i),
        .rst_i               (rst_i),
        .supply_level_i      (lvl),
        .bus_req_i           (req),
        .bus_rdata_o         (rdata),
        .operate_threshold_o (op_th),
        .release_threshold_o (rel_th),
        .locked_o            (locked),
        .fuse_blow_o         (blow),
        .fuse_sel_o          (sel)
    );

    pcf_prog_model u_prog (
        .ref_clk_i      (ref_clk_i),
        .start_i        (start),
        .key_n_i        (key_n),
        .addr_n_i       (addr_n),
        .op_i           (op),
        .supply_level_o (lvl),
        .busy_o         (busy)
    );

    initial begin
        ref_clk_i = 1'b0;
        forever #25 ref_clk_i = ~ref_clk_i;
    end

    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (blow === 1'b1) begin
            nblow <= nblow + 1;
            last_sel <= sel;
        end
        if (cyc == 110000) begin
            n_fail++;
            stop_test();
        end
    end

    task automatic stop_test();
        if (n_fail == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    function automatic logic [5:0] rel(input logic [5:0] o);
        return (o >= HYST_STEPS) ? o - HYST_STEPS : 6'h00;
    endfunction

    task automatic bus_wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge ref_clk_i);
        req.wr <= 1'b1;
        req.addr <= a;
        req.wdata <= v;
        @(posedge ref_clk_i);
        req.wr <= 1'b0;
    endtask

    task automatic bus_rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge ref_clk_i);
        req.rd <= 1'b1;
        req.addr <= a;
        @(posedge ref_clk_i);
        req.rd <= 1'b0;
        @(posedge ref_clk_i);
        v = rdata;
    endtask

    task automatic launch(input logic [3:0] k, input logic [6:0] a,
                          input logic [1:0] o);
        @(posedge ref_clk_i);
        start <= 1'b1;
        key_n <= k;
        addr_n <= a;
        op <= o;
        @(posedge ref_clk_i);
        start <= 1'b0;
    endtask

    task automatic settle();
        @(posedge ref_clk_i);
        while (busy === 1'b1) @(posedge ref_clk_i);
        repeat (8) @(posedge ref_clk_i);
    endtask

    // state read while a keying pulse pair is under way
    task automatic key_probe(input logic [1:0] exp);
        launch(4'h0, 7'h00, 2'h0);
        repeat (450) @(posedge ref_clk_i);
        bus_rd(REG_STATUS, d);
        chk(32'(d[1:0]), 32'(exp));
        settle();
    endtask

    task automatic t_reset();
        chk(32'(op_th), 32'h0);
        chk(32'(locked), 32'h0);
        bus_rd(REG_CTRL, d);
        chk(d, 32'(CTRL_RESET));
        @(posedge ref_clk_i);
        chk(rdata, 32'h0);
        bus_rd(4'h2, d);
        chk(d, 32'h0);
    endtask

    task automatic t_prov();
        launch(4'h7, 7'h01, 2'h1);
        settle();
        chk(32'(op_th), 32'h01);
        chk(32'(nblow), 32'h0);
        launch(4'h7, 7'h04, 2'h1);
        settle();
        chk(32'(op_th), 32'h09);
        chk(32'(rel_th), 32'(rel(6'h09)));
        bus_rd(REG_CAL, d);
        chk(32'(d[21:16]), 32'h09);
        launch(4'h0, 7'h00, 2'h3);
        settle();
        chk(32'(op_th), 32'h0);
        chk(32'(rel_th), 32'h0);
    endtask

    task automatic t_key_short();
        launch(4'h6, 7'h00, 2'h0);
        settle();
        bus_rd(REG_STATUS, d);
        chk(32'(d[1:0]), 32'h0);
    endtask

    task automatic t_ctrl();
        bus_wr(REG_CTRL, 32'h0);
        key_probe(2'h0);
        bus_wr(REG_CTRL, 32'(CTRL_RESET));
        key_probe(2'h1);
    endtask

    task automatic t_perm();
        launch(4'h7, 7'h03, 2'h2);
        settle();
        chk(32'(nblow), 32'h1);
        chk(32'(last_sel), 32'h04);
        launch(4'h0, 7'h00, 2'h3);
        settle();
        chk(32'(op_th), 32'h04);
        chk(32'(rel_th), 32'(rel(6'h04)));
    endtask

    task automatic t_lock();
        chk(32'(locked), 32'h0);
        launch(4'h7, LOCK_ADDR, 2'h2);
        settle();
        chk(32'(last_sel), 32'h40);
        chk(32'(locked), 32'h1);
        key_probe(2'h0);
        chk(32'(op_th), 32'h04);
    endtask

    initial begin
        rst_i = 1'b1;
        req = '0;
        start = 1'b0;
        key_n = '0;
        addr_n = '0;
        op = '0;
        repeat (8) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_prov();
        t_key_short();
        t_ctrl();
        t_perm();
        t_lock();
        stop_test();
    end
endmodule // pulse_coded_fuse_programmer_tb_top
